// *** scr_regs.vh ***
`ifndef SCR_REGS_VH
`define SCR_REGS_VH
// control-register indices
`define SCR_IDX_MODE 4'h0
`define SCR_IDX_FAULT 4'h2
`define SCR_IDX_XLAT 4'h3
`define SCR_IDX_EXT 4'h4
`define SCR_IDX_PRIO 4'h8
// operating modes
`define SCR_MODE_LEGACY 2'h0
`define SCR_MODE_COMPAT 2'h1
`define SCR_MODE_LONG64 2'h2
// mode-control field positions
`define SCR_BIT_PAGING 31
`define SCR_BIT_CACHE_DIS 30
`define SCR_BIT_WT_INHIBIT 29
`define SCR_BIT_ALIGN_MASK 18
`define SCR_BIT_SUP_WP 16
`define SCR_BIT_NUM_ERR 5
`define SCR_BIT_COPROC_TYPE 4
`define SCR_BIT_TASK_SW 3
`define SCR_BIT_EMUL 2
`define SCR_BIT_MONITOR 1
`define SCR_BIT_PROT_EN 0
// writable mask of mode-control, coprocessor type excluded
`define SCR_MODE_WR_MASK 32'hE005002F
// reset values
`define SCR_RST_MODE 64'h0000000000000000
`define SCR_RST_WORD 64'h0000000000000000
`define SCR_RST_PRIO 4'h0
// fault codes
`define SCR_FAULT_NONE 2'h0
`define SCR_FAULT_GP 2'h1
`define SCR_FAULT_UD 2'h2
`define SCR_FAULT_NM 2'h3
`define SCR_GP_CODE 16'h0000
`endif

// *** scr_access_check.v ***
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.vh"
// combinational legality check of one control-register move
module scr_access_check (
    // request
    input wire [3:0] index_i,
    input wire [1:0] mode_i,
    input wire write_i,
    input wire rex_i,
    input wire [63:0] wdata_i,
    // verdict
    output reg [1:0] fault_o
);
    // reserved indices and priority outside 64-bit mode are undefined
    always @* begin
        fault_o = `SCR_FAULT_NONE;
        case (index_i)
            `SCR_IDX_MODE, `SCR_IDX_EXT: begin
                if (write_i && mode_i == `SCR_MODE_LONG64 && (|wdata_i[63:32]))
                    fault_o = `SCR_FAULT_GP; // [RULE_07]
            end
            `SCR_IDX_FAULT, `SCR_IDX_XLAT: fault_o = `SCR_FAULT_NONE;
            `SCR_IDX_PRIO: begin
                if (mode_i != `SCR_MODE_LONG64 || !rex_i)
                    fault_o = `SCR_FAULT_UD; // [RULE_14]
            end
            default: fault_o = `SCR_FAULT_UD; // [RULE_01] [RULE_21]
        endcase
    end
endmodule // scr_access_check
`default_nettype wire

// *** scr_width_view.v ***
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.vh"
// width shaping by operating mode, shared by reads and writes
module scr_width_view (
    input wire [1:0] mode_i,
    input wire [63:0] data_i,
    output wire [63:0] data_o
);
    // 64-bit mode passes whole word, size override has no say
    assign data_o = (mode_i == `SCR_MODE_LONG64) ? data_i // [RULE_04]
                                                 : {32'h00000000, data_i[31:0]}; // [RULE_02]
endmodule // scr_width_view
`default_nettype wire

// *** scr_control_regs.v ***
// Contract
// (RULE_01) indices 1,5-7,9-15 have no storage
// (RULE_02) legacy mode shows 32-bit registers and flags
// (RULE_03) feature-enable register is always 64 bits
// (RULE_04) 64-bit mode moves all 64 bits
// (RULE_05) legacy write zero-fills upper 32 bits
// (RULE_06) legacy read returns low 32 bits
// (RULE_07) 64-bit nonzero upper write faults, code zero
// (RULE_08) fault-address fully writable, unchecked
// (RULE_09) page fault loads faulting address
// (RULE_10) translation base holds table address, cache bits
// (RULE_11) software keeps unimplemented address bits zero
// (RULE_12) flags upper 32 bits read zero
// (RULE_13) flags upper writes dropped, no fault
// (RULE_14) priority register only 64-bit with prefix
// (RULE_15) legacy view equals bits 31 to 0
// (RULE_16) paging, cache, write-through, align bits placed
// (RULE_17) write-protect and numeric-error bits placed
// (RULE_18) coprocessor-type read-only, ts, em, mp placed
// (RULE_19) bit 0 enables protected mode
// (RULE_20) monitor and task-switched make wait fault; a wait in the same cycle as a move request gets no fault
// (RULE_21) reserved index move faults, changes nothing
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.vh"
module scr_control_regs (
    // clock and reset
    input wire clk_i,
    input wire reset_i,
    // operating mode and strap
    input wire [1:0] mode_i,
    input wire coproc_type_i,
    // control-register move request
    input wire move_valid_i,
    input wire move_write_i,
    input wire move_rex_i,
    input wire [3:0] move_index_i,
    input wire [63:0] move_wdata_i,
    // flags register access
    input wire flags_write_i,
    input wire [63:0] flags_wdata_i,
    // feature-enable register access
    input wire extended_feature_enable_register_write_i,
    input wire [63:0] extended_feature_enable_register_wdata_i,
    // page fault report
    input wire page_fault_i,
    input wire [63:0] fault_vaddr_i,
    // wait-for-coprocessor instruction
    input wire wait_exec_i,
    // move answer
    output reg move_done_o,
    output reg [63:0] move_rdata_o,
    output reg [1:0] fault_o,
    output reg [15:0] fault_code_o,
    // register views
    output reg [63:0] flags_o,
    output reg [63:0] extended_feature_enable_register_o,
    output reg [63:0] mode_ctrl_o,
    output reg [63:0] xlat_base_o,
    output reg [3:0] prio_o,
    output reg protected_mode_o,
    output reg paging_o
);
    reg [63:0] mode_q;
    reg [63:0] fault_addr_q;
    reg [63:0] xlat_q;
    reg [63:0] ext_q;
    reg [31:0] flags_q;
    reg [63:0] extended_feature_enable_register_q;
    reg [3:0] prio_q;
    reg type_q;
    wire [1:0] chk_fault;
    wire [63:0] wr_view;
    reg [63:0] rd_raw;
    wire [63:0] rd_view;
    wire wr_ok;

    // legality check of the move
    scr_access_check u_check (
        .index_i(move_index_i),
        .mode_i(mode_i),
        .write_i(move_write_i),
        .rex_i(move_rex_i),
        .wdata_i(move_wdata_i),
        .fault_o(chk_fault)
    );

    // write data trimmed to operating width
    scr_width_view u_wview (
        .mode_i(mode_i),
        .data_i(move_wdata_i),
        .data_o(wr_view)
    );

    // read data trimmed to operating width
    scr_width_view u_rview (
        .mode_i(mode_i),
        .data_i(rd_raw),
        .data_o(rd_view)
    );

    assign wr_ok = move_valid_i && move_write_i && (chk_fault == `SCR_FAULT_NONE);

    // read mux of implemented indices
    always @* begin
        case (move_index_i)
            `SCR_IDX_MODE: rd_raw = mode_q; // [RULE_15]
            `SCR_IDX_FAULT: rd_raw = fault_addr_q;
            `SCR_IDX_XLAT: rd_raw = xlat_q;
            `SCR_IDX_EXT: rd_raw = ext_q;
            `SCR_IDX_PRIO: rd_raw = {60'h000000000000000, prio_q};
            default: rd_raw = 64'h0000000000000000; // [RULE_01]
        endcase
    end

    // coprocessor-type strap sampled on every clock, during reset as well
    always @(posedge clk_i) begin
        type_q <= coproc_type_i;
    end

    // register storage; faulting moves leave everything alone
    always @(posedge clk_i) begin
        if (reset_i) begin
            mode_q <= `SCR_RST_MODE;
            fault_addr_q <= `SCR_RST_WORD;
            xlat_q <= `SCR_RST_WORD;
            ext_q <= `SCR_RST_WORD;
            flags_q <= 32'h00000000;
            extended_feature_enable_register_q <= `SCR_RST_WORD;
            prio_q <= `SCR_RST_PRIO;
        end else begin
            if (wr_ok) begin // [RULE_21]
                case (move_index_i)
                    `SCR_IDX_MODE: begin
                        // reserved bits stay zero, type bit is read-only
                        mode_q <= {wr_view[63:32],
                                   wr_view[31:0] & `SCR_MODE_WR_MASK}; // [RULE_16] [RULE_17] [RULE_18] [RULE_05]
                    end
                    `SCR_IDX_FAULT: fault_addr_q <= wr_view; // [RULE_08]
                    // unimplemented address bits are software's to keep zero
                    `SCR_IDX_XLAT: xlat_q <= wr_view; // [RULE_10] [RULE_11]
                    `SCR_IDX_EXT: ext_q <= wr_view; // [RULE_05]
                    `SCR_IDX_PRIO: prio_q <= move_wdata_i[3:0]; // [RULE_14]
                    default: mode_q <= mode_q;
                endcase
            end
            // page fault wins over a same-cycle move write
            if (page_fault_i)
                fault_addr_q <= fault_vaddr_i; // [RULE_09]
            if (flags_write_i)
                flags_q <= flags_wdata_i[31:0]; // [RULE_13]
            if (extended_feature_enable_register_write_i)
                extended_feature_enable_register_q <= extended_feature_enable_register_wdata_i; // [RULE_03]
        end
    end

    // move answer and fault report, one cycle after the request
    always @(posedge clk_i) begin
        if (reset_i) begin
            move_done_o <= 1'b0;
            move_rdata_o <= 64'h0000000000000000;
            fault_o <= `SCR_FAULT_NONE;
            fault_code_o <= 16'h0000;
        end else begin
            move_done_o <= move_valid_i;
            fault_o <= `SCR_FAULT_NONE;
            fault_code_o <= 16'h0000;
            if (move_valid_i) begin
                fault_o <= chk_fault; // [RULE_21]
                if (chk_fault == `SCR_FAULT_GP)
                    fault_code_o <= `SCR_GP_CODE; // [RULE_07]
                if (!move_write_i && chk_fault == `SCR_FAULT_NONE) begin
                    if (move_index_i == `SCR_IDX_MODE)
                        move_rdata_o <= {rd_view[63:32],
                                         rd_view[31:`SCR_BIT_NUM_ERR],
                                         type_q, rd_view[3:0]}; // [RULE_18] [RULE_06]
                    else
                        move_rdata_o <= rd_view; // [RULE_06] [RULE_04]
                end
            end else if (wait_exec_i && mode_q[`SCR_BIT_MONITOR] && mode_q[`SCR_BIT_TASK_SW]) begin
                fault_o <= `SCR_FAULT_NM; // [RULE_20]
            end
        end
    end

    // register views to the core
    always @(posedge clk_i) begin
        if (reset_i) begin
            flags_o <= 64'h0000000000000000;
            extended_feature_enable_register_o <= 64'h0000000000000000;
            mode_ctrl_o <= 64'h0000000000000000;
            xlat_base_o <= 64'h0000000000000000;
            prio_o <= 4'h0;
            protected_mode_o <= 1'b0;
            paging_o <= 1'b0;
        end else begin
            flags_o <= {32'h00000000, flags_q}; // [RULE_12] [RULE_02]
            extended_feature_enable_register_o <= extended_feature_enable_register_q; // [RULE_03]
            mode_ctrl_o <= {mode_q[63:5], type_q, mode_q[3:0]};
            xlat_base_o <= xlat_q;
            prio_o <= prio_q;
            protected_mode_o <= mode_q[`SCR_BIT_PROT_EN]; // [RULE_19]
            paging_o <= mode_q[`SCR_BIT_PAGING]; // [RULE_16]
        end
    end
endmodule // scr_control_regs
`default_nettype wire

// *** scr_control_regs_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.vh"
module scr_control_regs_props (
    // clock, reset, request
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [1:0] mode_i,
    input wire logic move_valid_i,
    input wire logic move_write_i,
    input wire logic [3:0] move_index_i,
    input wire logic [63:0] move_wdata_i,
    input wire logic wait_exec_i,
    // answers and views
    input wire logic [1:0] fault_o,
    input wire logic [15:0] fault_code_o,
    input wire logic [63:0] move_rdata_o,
    input wire logic [63:0] flags_o,
    input wire logic [63:0] mode_ctrl_o,
    input wire logic protected_mode_o,
    input wire logic paging_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic rsvd;
    logic gp;
    // request classes: reserved index, upper-half write to index 0 or 4
    assign rsvd = move_index_i == 4'h1 || (move_index_i > 4'h4 && move_index_i != 4'h8);
    assign gp = move_valid_i && move_write_i && mode_i == `SCR_MODE_LONG64 &&
        move_index_i[1:0] == 2'h0 && move_index_i < 4'h5 && |move_wdata_i[63:32];
    AST_RSVD_IDX: assert property (move_valid_i && rsvd |=> fault_o == `SCR_FAULT_UD)
        else $error("reserved index accepted");
    AST_GP_UPPER: assert property (gp |=> fault_o == `SCR_FAULT_GP && fault_code_o == 16'h0)
        else $error("upper write not refused");
    AST_FLAGS_HI: assert property (flags_o[63:32] == 32'h0)
        else $error("flags upper half set");
    AST_MODE_HI: assert property (mode_ctrl_o[63:32] == 32'h0)
        else $error("mode upper half set");
    AST_MODE_RSVD: assert property ((mode_ctrl_o[31:0] & ~32'hE005003F) == 32'h0)
        else $error("reserved mode bit set");
    AST_VIEWS: assert property (protected_mode_o == mode_ctrl_o[0] &&
        paging_o == mode_ctrl_o[31]) else $error("mode views differ");
    // wait judged only once no move can still be reshaping the view
    AST_WAIT: assert property (wait_exec_i && !move_valid_i && !$past(move_valid_i) &&
        !$past(move_valid_i, 2) |=> (fault_o == `SCR_FAULT_NM) == (mode_ctrl_o[1] && mode_ctrl_o[3]))
        else $error("wait fault wrong");
    AST_LEG_RD: assert property (move_valid_i && !move_write_i &&
        mode_i != `SCR_MODE_LONG64 ##1 fault_o == `SCR_FAULT_NONE |-> move_rdata_o[63:32] == 32'h0)
        else $error("legacy read upper set");
    cover property (move_valid_i && rsvd);
    cover property (gp);
    cover property (wait_exec_i && mode_ctrl_o[1] && mode_ctrl_o[3]);
endmodule // scr_control_regs_props
bind scr_control_regs scr_control_regs_props scr_control_regs_props_inst (.*);
`default_nettype wire

// *** scr_exec_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.vh"
module scr_exec_model #(parameter int PA_BITS = 52) (
    input wire logic clk_i,
    // operands and strobes: move, flags, extended_feature_enable_register, page fault, wait
    output logic wr_o,
    output logic rex_o,
    output logic [3:0] idx_o,
    output logic [63:0] wd_o,
    output logic [4:0] st_o
);
    localparam logic [63:0] PA_MASK = (64'h1 << PA_BITS) - 64'h1;
    // one request held a full cycle, changed on falling edges only
    task automatic op(input int k, input logic w, input logic r,
        input logic [3:0] i, input logic [63:0] d);
        @(negedge clk_i);
        st_o = 5'h01 << k;
        wr_o = w;
        rex_o = r;
        idx_o = i;
        wd_o = (k == 0 && i == `SCR_IDX_XLAT) ? d & PA_MASK : d;
        @(negedge clk_i);
        st_o = 5'h00;
        wd_o = ~wd_o; // released data must not linger as valid
    endtask
    initial begin
        {st_o, wr_o, rex_o, idx_o, wd_o} = '0;
    end
endmodule // scr_exec_model
`default_nettype wire

// *** tb_scr_control_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.vh"
module tb_scr_control_regs;
    logic clk_i, reset_i, coproc_type_i, wr, rex, done, pe, pg;
    logic [1:0] mode_i, fault;
    logic [3:0] idx;
    logic [4:0] st;
    logic [15:0] code;
    logic [63:0] wd, rd, flags, extended_feature_enable_register, mctl;
    int err_total = 0, check_count = 0, cyc = 0;
    scr_control_regs scr_control_regs_inst (.clk_i(clk_i), .reset_i(reset_i), .mode_i(mode_i),
        .coproc_type_i(coproc_type_i), .move_valid_i(st[0]), .move_write_i(wr),
        .move_rex_i(rex), .move_index_i(idx), .move_wdata_i(wd), .flags_write_i(st[1]),
        .flags_wdata_i(wd), .extended_feature_enable_register_write_i(st[2]), .extended_feature_enable_register_wdata_i(wd), .page_fault_i(st[3]),
        .fault_vaddr_i(wd), .wait_exec_i(st[4]), .move_done_o(done), .move_rdata_o(rd),
        .fault_o(fault), .fault_code_o(code), .flags_o(flags), .extended_feature_enable_register_o(extended_feature_enable_register),
        .mode_ctrl_o(mctl), .xlat_base_o(), .prio_o(), .protected_mode_o(pe), .paging_o(pg));
    scr_exec_model scr_exec_model_inst (.clk_i(clk_i), .wr_o(wr), .rex_o(rex), .idx_o(idx),
        .wd_o(wd), .st_o(st));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one move; one-cycle answer sampled at the falling edge while it stands
    task automatic mv_t(input logic w, input logic r, input logic [3:0] i,
        input logic [63:0] d, input logic [1:0] f);
        scr_exec_model_inst.op(0, w, r, i, d);
        chk({63'h0, done}, 64'h1);
        chk({62'h0, fault}, {62'h0, f});
        if (f == `SCR_FAULT_GP) chk({48'h0, code}, 64'h0);
        if (!w && f == `SCR_FAULT_NONE) chk(rd, d);
    endtask
    // side strobe after a quiet gap, then its fault and settled views
    task automatic pulse(input int k, input logic [63:0] d, input logic [1:0] f);
        repeat (2) @(posedge clk_i);
        scr_exec_model_inst.op(k, 1'b0, 1'b0, 4'h0, d);
        chk({62'h0, fault}, {62'h0, f});
        @(posedge clk_i);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // hang guard, well beyond the roughly 80 cycles needed
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            print_verdict;
        end
    end
    initial begin
        reset_i = 1'b1;
        mode_i = `SCR_MODE_LONG64;
        coproc_type_i = 1'b1;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        mv_t(1, 0, `SCR_IDX_XLAT, 64'hFFFF_FFFF_FFFF_F018, 0);
        mv_t(0, 0, `SCR_IDX_XLAT, 64'h000F_FFFF_FFFF_F018, 0);
        mv_t(1, 0, `SCR_IDX_FAULT, 64'hDEAD_0000_0000_0001, 0);
        mv_t(0, 0, `SCR_IDX_FAULT, 64'hDEAD_0000_0000_0001, 0);
        pulse(3, 64'hFFFF_8000_1234_5678, 0);
        mv_t(0, 0, `SCR_IDX_FAULT, 64'hFFFF_8000_1234_5678, 0);
        mv_t(1, 0, `SCR_IDX_MODE, 64'h0000_0001_0000_0000, `SCR_FAULT_GP);
        mv_t(1, 0, `SCR_IDX_EXT, 64'h8000_0000_0000_0000, `SCR_FAULT_GP);
        mv_t(1, 1, `SCR_IDX_PRIO, 64'h5, 0);
        mv_t(0, 1, `SCR_IDX_PRIO, 64'h5, 0);
        mv_t(0, 0, `SCR_IDX_PRIO, 64'h5, `SCR_FAULT_UD);
        for (int i = 1; i < 16; i++)
            if (!(i inside {2, 3, 4, 8})) mv_t(i[0], 0, i[3:0], 64'h0, `SCR_FAULT_UD);
        $display("test wide moves done");
        mv_t(1, 0, `SCR_IDX_MODE, 64'hFFFF_FFFF, 0);
        mv_t(0, 0, `SCR_IDX_MODE, 64'hE005_003F, 0);
        chk({62'h0, pg, pe}, 64'h3);
        pulse(4, 64'h0, `SCR_FAULT_NM);
        mv_t(1, 0, `SCR_IDX_MODE, 64'h2, 0);
        pulse(4, 64'h0, `SCR_FAULT_NONE);
        $display("test mode control done");
        @(negedge clk_i);
        mode_i = `SCR_MODE_LEGACY;
        mv_t(0, 0, `SCR_IDX_XLAT, 64'hFFFF_F018, 0);
        mv_t(0, 1, `SCR_IDX_PRIO, 64'h0, `SCR_FAULT_UD);
        pulse(1, 64'hFFFF_FFFF_1234_5678, 0);
        chk(flags, 64'h1234_5678);
        pulse(2, 64'h8000_0000_0000_0D01, 0);
        chk(extended_feature_enable_register, 64'h8000_0000_0000_0D01);
        @(negedge clk_i);
        mode_i = `SCR_MODE_COMPAT;
        mv_t(1, 0, `SCR_IDX_FAULT, 64'hAAAA_BBBB_CCCC_DDDD, 0);
        @(negedge clk_i);
        mode_i = `SCR_MODE_LONG64;
        mv_t(0, 0, `SCR_IDX_FAULT, 64'hCCCC_DDDD, 0);
        $display("test narrow modes done");
        print_verdict;
    end
endmodule // tb_scr_control_regs
`default_nettype wire
